// ---- config_host.sv ----
// behavioural model of the external configuration host
`timescale 1ns/10ps
module config_host (
    output logic config_clock,
    output logic reconfig_n,
    output logic user_init_clock,
    output logic [31:0] data_in,
    input wire logic status_wire
);
    // half period of the 400 ns link clock
    localparam time HALF = 200;
    // ----------------------------------------
    // idle pins
    // ----------------------------------------
    // clock driven low, never floating
    initial begin
        config_clock = 1'b0;
        reconfig_n = 1'b1;
        user_init_clock = 1'b0;
        data_in = 32'h0000_0000;
    end
    task automatic restart;
        // keep pin changes off the system clock edges
        #10;
        reconfig_n = 1'b0;
        #2100;
        reconfig_n = 1'b1;
    endtask : restart
    task automatic send_word(input logic [31:0] d, input int n);
        #10;
        data_in = d;
        repeat (n) begin
            #HALF;
            if (status_wire !== 1'b1) begin
                break;
            end
            config_clock = 1'b1;
            #HALF;
            config_clock = 1'b0;
        end
        // stale data would hide a late capture
        data_in = ~d;
    endtask : send_word
    task automatic falls(input int n);
        #10;
        repeat (n) begin
            #HALF config_clock = 1'b1;
            #HALF config_clock = 1'b0;
        end
    endtask : falls
    task automatic user_clocks(input int n);
        #10;
        repeat (n) begin
            #HALF user_init_clock = 1'b1;
            #HALF user_init_clock = 1'b0;
        end
    endtask : user_clocks
endmodule : config_host

// ---- passive_parallel_load.sv ----
// passive parallel configuration load port with axi4-lite registers
`timescale 1ns/10ps
module passive_parallel_load
    import ppl_pkg::*;
#(
    parameter int POR_CYC = STATUS_MIN_CYC,
    parameter int STATUS_CYC = STATUS_MIN_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    // link pins
    input wire logic config_clock,
    input wire logic user_init_clock,
    input wire logic reconfig_n,
    input wire logic [31:0] data_in,
    input wire logic status_n_i,
    output logic status_n_o,
    output logic status_n_oe,
    output logic load_done_o,
    output logic load_done_oe,
    output logic init_done_o,
    output logic init_done_oe,
    output logic user_pins_released,
    output logic [31:0] word_data,
    output logic word_valid,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------
    // pin synchronisers and edge finding
    // ------------------------------------------------
    logic [3:0] pins_s; // synced pins
    logic cclk_prev_q; // config clock last sample
    logic uclk_prev_q; // user clock last sample
    logic cclk_rise; // config clock rising
    logic cclk_fall; // config clock falling
    logic uclk_rise; // user clock rising
    logic req_n_s; // synced request
    logic status_line_s; // synced status wire

    pin_sync #(.WIDTH(4)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({config_clock, user_init_clock, reconfig_n, status_n_i}),
        .q(pins_s)
    );

    // data bus changes only around config clock edges, which the
    // host holds for ratio cycles, so it is synced as a word too
    logic [31:0] data_m_q; // data first stage
    logic [31:0] data_s_q; // data second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_m_q <= '0;
            data_s_q <= '0;
        end else begin
            data_m_q <= data_in;
            data_s_q <= data_m_q;
        end
    end

    assign req_n_s = pins_s[1];
    assign status_line_s = pins_s[0];

    // previous samples for edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cclk_prev_q <= 1'b0;
            uclk_prev_q <= 1'b0;
        end else begin
            cclk_prev_q <= pins_s[3];
            uclk_prev_q <= pins_s[2];
        end
    end
    assign cclk_rise = pins_s[3] & ~cclk_prev_q;
    assign cclk_fall = ~pins_s[3] & cclk_prev_q;
    assign uclk_rise = pins_s[2] & ~uclk_prev_q;

    // ------------------------------------------------
    // registers
    // ------------------------------------------------
    logic [5:0] ctrl_q; // width, features, init options
    logic [31:0] len_q; // image length in words
    logic [31:0] words_q; // words taken so far
    logic [31:0] last_q; // last word taken
    logic [1:0] width_sel;
    logic [3:0] ratio;
    assign width_sel = ctrl_q[CTRL_WIDTH_LSB+1:CTRL_WIDTH_LSB];
    assign ratio = word_ratio(width_sel, ctrl_q[CTRL_DECOMP],
                              ctrl_q[CTRL_SECURE]);

    // ------------------------------------------------
    // load sequencer
    // ------------------------------------------------
    state_type state_q; // sequencer state
    logic [31:0] cnt_q; // general timer
    logic [3:0] phase_q; // clock within word
    logic [1:0] falls_q; // falling edges after load
    logic [13:0] uedges_q; // user clock edges

    // timer and edge counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= st_por;
            cnt_q <= '0;
            phase_q <= '0;
            falls_q <= '0;
            uedges_q <= '0;
            words_q <= '0;
            last_q <= '0;
        end else if (!req_n_s && state_q != st_por) begin
            state_q <= st_clear;
            cnt_q <= '0;
            phase_q <= '0;
            falls_q <= '0;
            uedges_q <= '0;
            words_q <= '0;
        end else begin
            case (state_q)
                st_por: begin
                    if (cnt_q >= 32'(POR_CYC - 1) && req_n_s) begin
                        state_q <= st_status;
                        cnt_q <= '0;
                    end else if (cnt_q < 32'(POR_CYC - 1)) begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                // request released: start status timer
                st_clear: begin
                    state_q <= st_status;
                    cnt_q <= '0;
                end
                // status low for the fixed pulse
                st_status: begin
                    if (cnt_q >= 32'(STATUS_CYC - 1)) begin
                        // external low holds us here
                        if (status_line_s) begin
                            state_q <= st_load;
                        end
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
                // one word per ratio rising edges
                st_load: begin
                    if (cclk_rise) begin
                        if (phase_q == 4'h0) begin
                            last_q <= data_s_q & lane_mask(width_sel);
                            words_q <= words_q + 32'h1;
                        end
                        if (phase_q == ratio - 4'h1) begin
                            phase_q <= 4'h0;
                            // release only after all data
                            // a one-clock word is counted in this edge
                            if (words_q + 32'(phase_q == 4'h0) >= len_q) begin
                                state_q <= st_edges;
                                cnt_q <= '0;
                            end
                        end else begin
                            phase_q <= phase_q + 4'h1;
                        end
                    end
                end
                st_edges: begin
                    cnt_q <= cnt_q + 32'h1;
                    if (cclk_fall) begin
                        falls_q <= falls_q + 2'h1;
                        if (falls_q == 2'(FALL_EDGES_NEEDED - 1)) begin
                            state_q <= st_init;
                        end
                    end
                end
                st_init: begin
                    cnt_q <= cnt_q + 32'h1;
                    if (ctrl_q[CTRL_USRCLK]) begin
                        if (uclk_rise) begin
                            uedges_q <= uedges_q + 14'h1;
                        end
                        if (uedges_q >= 14'(USER_INIT_EDGES)) begin
                            state_q <= st_user;
                        end
                    end else if (cnt_q >= 32'(INIT_OSC_CYC - 1)) begin
                        state_q <= st_user;
                    end
                end
                // config clock ignored in user mode
                st_user: state_q <= st_user;
                default: state_q <= st_por;
            endcase
        end
    end

    // ------------------------------------------------
    // pin drivers, all registered
    // ------------------------------------------------
    // open-drain lines only ever pull low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_n_o <= 1'b0;
            load_done_o <= 1'b0;
            init_done_o <= 1'b0;
            status_n_oe <= 1'b1;
            load_done_oe <= 1'b1;
            init_done_oe <= 1'b0;
            user_pins_released <= 1'b0;
        end else begin
            // request low pulls both lines next cycle
            // let go once the pulse is over, so an external hold
            // on the wire can be read back through the input
            status_n_oe <= !req_n_s || state_q == st_por ||
                           state_q == st_clear ||
                           (state_q == st_status &&
                            cnt_q < 32'(STATUS_CYC - 1));
            load_done_oe <= !req_n_s || state_q == st_por ||
                            state_q == st_clear ||
                            state_q == st_status || state_q == st_load;
            init_done_oe <= ctrl_q[CTRL_INITEN] && req_n_s &&
                            state_q != st_user;
            // data pins go to user function
            user_pins_released <= req_n_s && state_q == st_user;
        end
    end

    // captured word stream toward the core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_data <= '0;
            word_valid <= 1'b0;
        end else begin
            word_valid <= req_n_s && state_q == st_load &&
                          cclk_rise && phase_q == 4'h0;
            // hold the last captured word between captures
            if (req_n_s && state_q == st_load && cclk_rise &&
                phase_q == 4'h0) begin
                word_data <= data_s_q & lane_mask(width_sel);
            end
        end
    end

    // ------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------
    logic aw_got_q; // address held
    logic w_got_q; // data held
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write;
    assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;

    // take address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_got_q && !s_axi_awready;
            s_axi_wready <= !w_got_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
        end
    end

    // register update and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
            len_q <= LEN_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                case (awaddr_q)
                    OFS_CTRL: if (wstrb_q[0]) begin
                        ctrl_q <= wdata_q[5:0];
                    end
                    OFS_LEN: begin
                        for (int b = 0; b < 4; b++) begin
                            if (wstrb_q[b]) begin
                                len_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
                            end
                        end
                    end
                    OFS_STAT, OFS_WORDS, OFS_LAST: ;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end
        end
    end

    // ------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------
    // read answers on the same edge that takes the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
                             s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                case (s_axi_araddr)
                    OFS_CTRL: s_axi_rdata <= {26'h0, ctrl_q};
                    OFS_LEN: s_axi_rdata <= len_q;
                    OFS_STAT: s_axi_rdata <= {24'h0, ratio,
                        user_pins_released, 3'(state_q)};
                    OFS_WORDS: s_axi_rdata <= words_q;
                    OFS_LAST: s_axi_rdata <= last_q;
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RATIO_32: assert property (
        width_sel == W32 && ctrl_q[CTRL_DECOMP] |-> ratio == 4'h8)
        else $error("ratio wrong for wide compressed load");
    AST_LANES: assert property (
        word_valid && width_sel == W8 |-> word_data[31:8] == 24'h0)
        else $error("upper lanes leaked in narrow mode");
    AST_RELEASE: assert property (
        user_pins_released |-> !load_done_oe && !status_n_oe)
        else $error("pins released before load finished");
    AST_PULL: assert property (
        $fell(req_n_s) |=> status_n_oe && load_done_oe)
        else $error("lines not pulled after request fell");
    AST_STAT_MIN: assert property (
        $rose(req_n_s) |=> status_n_oe [*8])
        else $error("status released too soon");
    AST_LOADLOW: assert property (
        state_q == st_load |=> load_done_oe || !req_n_s ||
        state_q != st_load)
        else $error("load-complete released mid load");
    AST_EDGES: assert property (
        state_q == st_edges && falls_q == 2'h0 |-> !user_pins_released)
        else $error("user mode before closing edges");
    AST_INITLOW: assert property (
        $past(ctrl_q[CTRL_INITEN]) && state_q == st_init && req_n_s
        |=> init_done_oe)
        else $error("init-complete not held low");
    AST_IGNORE: assert property (
        state_q == st_user && req_n_s |=> state_q == st_user)
        else $error("config clock disturbed user mode");

    COV_LOAD: cover property (state_q == st_load ##1 state_q == st_edges);
    COV_USER: cover property ($rose(user_pins_released));
    COV_RESTART: cover property (state_q == st_user ##1 !req_n_s);
endmodule : passive_parallel_load

// ---- pin_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    // first stage, read only by second stage
    logic [WIDTH-1:0] meta_q;

    // ----------------------------------------
    // two stages
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : pin_sync

// ---- ppl_pkg.sv ----
// constants and types shared by the passive parallel load block
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package ppl_pkg;
    // clock rate
    localparam int CLK_MHZ = 20;
    // request-to-low limit, longest time rounds down
    localparam int T_PULL_LOW_NS = 600;
    localparam int PULL_LOW_CYC = T_PULL_LOW_NS * CLK_MHZ / 1000;
    // status low pulse, least time rounds up
    localparam int T_STATUS_MIN_US = 268;
    localparam int STATUS_MIN_CYC = T_STATUS_MIN_US * CLK_MHZ;
    localparam int T_STATUS_MAX_US = 1506;
    // oscillator initialisation window
    localparam int T_INIT_MIN_US = 175;
    localparam int INIT_OSC_CYC = T_INIT_MIN_US * CLK_MHZ;
    localparam int T_INIT_MAX_US = 437;
    // user clock initialisation
    localparam int USER_INIT_EDGES = 8576;
    localparam int FALL_EDGES_NEEDED = 2;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LEN = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_WORDS = 8'h0c;
    localparam logic [7:0] OFS_LAST = 8'h10;
    // ctrl field positions
    localparam int CTRL_WIDTH_LSB = 0;
    localparam int CTRL_DECOMP = 2;
    localparam int CTRL_SECURE = 3;
    localparam int CTRL_USRCLK = 4;
    localparam int CTRL_INITEN = 5;
    // reset values
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [31:0] LEN_RST = 32'h0000_0010;
    // width codes
    localparam logic [1:0] W8 = 2'h0;
    localparam logic [1:0] W16 = 2'h1;
    localparam logic [1:0] W32 = 2'h2;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // load sequencer states
    typedef enum logic [2:0] {
        st_por, st_clear, st_status, st_load,
        st_edges, st_init, st_user
    } state_type;

    // clocks per word for width and features
    function automatic logic [3:0] word_ratio(
        input logic [1:0] w, input logic dec, input logic sec);
        logic [3:0] r;
        r = 4'h1;
        case (w)
            W8: r = dec ? 4'h2 : 4'h1;
            W16: r = dec ? 4'h4 : (sec ? 4'h2 : 4'h1);
            default: r = dec ? 4'h8 : (sec ? 4'h4 : 4'h1);
        endcase
        return r;
    endfunction : word_ratio

    // lane mask for the selected width
    function automatic logic [31:0] lane_mask(input logic [1:0] w);
        case (w)
            W8: return 32'h0000_00ff;
            W16: return 32'h0000_ffff;
            default: return 32'hffff_ffff;
        endcase
    endfunction : lane_mask
endpackage : ppl_pkg

// ---- test_passive_parallel_load.sv ----
// self-checking bench for the passive parallel load block
`timescale 1ns/10ps
module test_passive_parallel_load;
    import ppl_pkg::*;
    // shortened power-on and status delays
    localparam int SC = 16;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic cclk, uclk, req_n, st_i;
    logic [31:0] din, wd, rda;
    logic so, soe, lo, loe, io, ioe, rel, wv;
    logic [7:0] awa = 8'h00;
    logic [7:0] ara = 8'h00;
    logic [31:0] wda = 32'h0000_0000;
    logic awv = 1'b0;
    logic wvl = 1'b0;
    logic brd = 1'b0;
    logic arv = 1'b0;
    logic rrd = 1'b0;
    logic awr, wr, bv, arr, rv;
    logic [1:0] br, rr;
    int failures = 0;
    int tests_run = 0;
    int since_done = 0;
    // cycles since load-complete was released
    always @(posedge aclk)
        since_done <= (loe === 1'b0) ? since_done + 1 : 0;
    // ----------------------------------------
    // clock, wire and instances
    // ----------------------------------------
    always #25 aclk = ~aclk;
    // status wire has a pull-up
    assign st_i = ~soe;
    config_host host (.config_clock(cclk), .reconfig_n(req_n),
        .user_init_clock(uclk), .data_in(din), .status_wire(st_i));
    passive_parallel_load #(.POR_CYC(SC), .STATUS_CYC(SC)) dut (
        .aclk(aclk), .aresetn(aresetn), .config_clock(cclk),
        .user_init_clock(uclk), .reconfig_n(req_n), .data_in(din),
        .status_n_i(st_i), .status_n_o(so), .status_n_oe(soe),
        .load_done_o(lo), .load_done_oe(loe), .init_done_o(io),
        .init_done_oe(ioe), .user_pins_released(rel),
        .word_data(wd), .word_valid(wv), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wda),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvl), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rda), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rrd));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // write; address and data released as each is taken
    task automatic wrt(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] e);
        int n;
        logic pa, pw;
        n = 0;
        pa = 1'b1;
        pw = 1'b1;
        awa <= a;
        wda <= d;
        awv <= 1'b1;
        wvl <= 1'b1;
        brd <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (pa && awr) begin
                pa = 1'b0;
                awv <= 1'b0;
            end
            if (pw && wr) begin
                pw = 1'b0;
                wvl <= 1'b0;
            end
            if (bv === 1'b1 || n > 50) break;
        end
        brd <= 1'b0;
        check(bv, 1'b1);
        check(br, e);
        // let an edge pass before the next request
        @(posedge aclk);
    endtask : wrt
    task automatic rdr(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        int n;
        logic pa;
        n = 0;
        pa = 1'b1;
        ara <= a;
        arv <= 1'b1;
        rrd <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (pa && arr) begin
                pa = 1'b0;
                arv <= 1'b0;
            end
            if (rv === 1'b1 || n > 50) break;
        end
        rrd <= 1'b0;
        check(rv, 1'b1);
        check(rda, e);
        check(rr, er);
        @(posedge aclk);
    endtask : rdr
    // bounded wait for status release
    task automatic wait_status(output int n);
        n = 0;
        while (soe !== 1'b0 && n < 300) begin
            @(posedge aclk);
            n++;
        end
    endtask : wait_status
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        int n;
        repeat (6) @(posedge aclk);
        check(soe, 1);
        check(loe, 1);
        check({so, lo, io}, 0);
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        wait_status(n);
        check(n >= 2 * SC && n < 300, 1);
        check(loe, 1);
    endtask : t_reset
    task automatic t_regs;
        rdr(OFS_CTRL, 32'h0, RESP_OKAY);
        rdr(OFS_LEN, LEN_RST, RESP_OKAY);
        rdr(8'h40, 32'h0, RESP_SLVERR);
        wrt(8'h40, 32'h1, RESP_SLVERR);
    endtask : t_regs
    // eight-bit load with init-complete on
    task automatic t_load8;
        int n;
        wrt(OFS_LEN, 32'h2, RESP_OKAY);
        wrt(OFS_CTRL, 32'h20, RESP_OKAY);
        #2100;
        host.send_word(32'ha5a5_3c5a, 1);
        repeat (6) @(posedge aclk);
        check(wd, 32'h0000_005a);
        check(loe, 1);
        host.send_word(32'h1234_5678, 1);
        repeat (6) @(posedge aclk);
        check(wd, 32'h0000_0078);
        check(loe, 0);
        check(rel, 0);
        host.falls(2);
        n = 0;
        while (rel !== 1'b1 && n < 9000) begin
            @(posedge aclk);
            n++;
            if (n == 100) check(ioe, 1);
        end
        check(since_done >= INIT_OSC_CYC &&
            since_done <= T_INIT_MAX_US * CLK_MHZ, 1);
        check(ioe, 0);
        check({soe, loe}, 0);
        rdr(OFS_WORDS, 32'h2, RESP_OKAY);
        rdr(OFS_LAST, 32'h78, RESP_OKAY);
    endtask : t_load8
    // clock edges in user mode take nothing
    task automatic t_ignore;
        int n;
        n = 0;
        fork
            host.send_word(32'hffff_ffff, 4);
            repeat (70) begin
                @(posedge aclk);
                n += wv;
            end
        join
        check(n, 0);
        check(rel, 1);
    endtask : t_ignore
    // restart, then 32-bit load at ratio eight
    task automatic t_reload32;
        int n;
        n = 0;
        fork
            host.restart;
            while (!(soe === 1'b1 && loe === 1'b1) && n < 40) begin
                @(posedge aclk);
                n++;
            end
        join
        check(n <= PULL_LOW_CYC, 1);
        check(rel, 0);
        wait_status(n);
        check(n < 300, 1);
        wrt(OFS_CTRL, 32'h16, RESP_OKAY);
        wrt(OFS_LEN, 32'h1, RESP_OKAY);
        #2100;
        host.send_word(32'hdead_beef, 7);
        repeat (6) @(posedge aclk);
        check(wd, 32'hdead_beef);
        check(loe, 1);
        host.send_word(32'hdead_beef, 1);
        repeat (6) @(posedge aclk);
        check(loe, 0);
        host.falls(2);
        host.user_clocks(USER_INIT_EDGES - 1);
        repeat (6) @(posedge aclk);
        check(rel, 0);
        host.user_clocks(1);
        repeat (6) @(posedge aclk);
        check(rel, 1);
    endtask : t_reload32
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        t_reset;
        t_regs;
        t_load8;
        t_ignore;
        t_reload32;
        end_of_test;
    end
    initial begin
        #4_500_000;
        failures++;
        end_of_test;
    end
endmodule : test_passive_parallel_load
